// File: logic/spi_cfg_pkg.sv
package spi_cfg_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_ADDR = 8'ha1;

    // Bit positions of serial_port_config
    localparam int BIT_BUSY = 7;
    localparam int BIT_ROLE = 6;
    localparam int BIT_PHASE = 5;
    localparam int BIT_POL = 4;
    localparam int BIT_SEL = 3;
    localparam int BIT_PIN = 2;
    localparam int BIT_SHEMPTY = 1;
    localparam int BIT_RXEMPTY = 0;

    // Reset values
    localparam logic RST_CTRL = 1'h0;
    localparam logic RST_SEL = 1'h0;
    localparam logic RST_PIN = 1'h1;
    localparam logic RST_EMPTY = 1'h1;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ------------------------------------------------------------
    // Timing and widths
    // ------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 100;
    // Select filter settle time in ns
    localparam int SEL_FILTER_NS = 40;
    localparam int SEL_FILTER_CYC = (SEL_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int BITS_PER_BYTE = 8;
    localparam int BITCNT_W = 3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic master_role_select;
        logic clock_phase_select;
        logic clock_idle_level;
    } ctrl_t;

    typedef struct packed {
        logic transfer_in_progress;
        logic selected_flag_filtered;
        logic select_pin_raw;
        logic shifter_empty;
        logic rx_holding_empty;
    } status_t;

    typedef struct packed {
        logic master_busy;
        logic tx_pending;
        logic tx_load;
        logic rx_byte_stored;
        logic rx_buf_read;
    } engine_t;

endpackage

// File: logic/select_filter.sv
`timescale 1ns/1ns
module select_filter #(
    parameter int FILTER_CYC = spi_cfg_pkg::SEL_FILTER_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin and results
    input wire logic pin_async,
    output logic level_raw,
    output logic level_filtered
);
    import spi_cfg_pkg::*;

    localparam int CW = $clog2(FILTER_CYC + 1);

    logic [2:0] sync_q;
    logic raw_q, raw_d;
    logic filt_q, filt_d;
    logic [CW-1:0] cnt_q, cnt_d;

    always_comb begin
        raw_d = raw_q;
        // Change accepted once stages two and three agree
        if (sync_q[1] == sync_q[2]) begin
            raw_d = sync_q[2];
        end
        filt_d = filt_q;
        cnt_d = cnt_q;
        if (raw_q == filt_q) begin
            cnt_d = '0;
        end else if (cnt_q == CW'(FILTER_CYC - 1)) begin
            filt_d = raw_q;
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= {3{RST_PIN}};
            raw_q <= RST_PIN;
            filt_q <= RST_PIN;
            cnt_q <= '0;
        end else begin
            sync_q <= {sync_q[1:0], pin_async};
            raw_q <= raw_d;
            filt_q <= filt_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_raw = raw_q;
    assign level_filtered = filt_q;

endmodule // select_filter

// File: logic/link_bit_counter.sv
`timescale 1ns/1ns
module link_bit_counter (
    // Link clock and frame
    input wire logic spi_sck,
    input wire logic rst_n,
    input wire logic slave_select_pin,
    // Events as toggles
    output logic edge_tgl,
    output logic byte_tgl
);
    import spi_cfg_pkg::*;

    // Frame end clears the counter; no sck edge is relied on outside a frame
    logic link_rst_n;
    logic [BITCNT_W-1:0] cnt_q, cnt_d;
    logic edge_q, edge_d;
    logic byte_q, byte_d;

    assign link_rst_n = rst_n & ~slave_select_pin;

    always_comb begin
        cnt_d = cnt_q + BITCNT_W'(1);
        // Idle-level changes between frames are not link events
        edge_d = slave_select_pin ? edge_q : ~edge_q;
        byte_d = byte_q;
        if (cnt_q == BITCNT_W'(BITS_PER_BYTE - 1)) begin
            byte_d = ~byte_q;
        end
    end

    always_ff @(posedge spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Toggles survive the frame reset so no event is lost
    always_ff @(posedge spi_sck or negedge rst_n) begin
        if (!rst_n) begin
            edge_q <= 1'h0;
            byte_q <= 1'h0;
        end else begin
            edge_q <= edge_d;
            byte_q <= byte_d;
        end
    end

    assign edge_tgl = edge_q;
    assign byte_tgl = byte_q;

endmodule // link_bit_counter

// File: logic/spi_config_status_reg.sv
`timescale 1ns/1ns
module spi_config_status_reg #(
    parameter int FILTER_CYC = spi_cfg_pkg::SEL_FILTER_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    // Shift engine
    input wire spi_cfg_pkg::engine_t engine,
    output spi_cfg_pkg::ctrl_t ctrl,
    output spi_cfg_pkg::status_t status,
    // Link pins
    input wire logic spi_sck,
    input wire logic slave_select_pin
);
    import spi_cfg_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic s);
        return s && (a == CFG_ADDR);
    endfunction

    // ------------------------------------------------------------
    // Link side and crossings
    // ------------------------------------------------------------
    logic edge_tgl, byte_tgl;
    logic sel_raw, sel_filt;
    logic [2:0] edge_sync_q, byte_sync_q;
    logic sck_event, byte_event;

    link_bit_counter u_link (
        .spi_sck(spi_sck),
        .rst_n(rst_n),
        .slave_select_pin(slave_select_pin),
        .edge_tgl(edge_tgl),
        .byte_tgl(byte_tgl)
    );

    select_filter #(.FILTER_CYC(FILTER_CYC)) u_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pin_async(slave_select_pin),
        .level_raw(sel_raw),
        .level_filtered(sel_filt)
    );

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_sync_q <= '0;
            byte_sync_q <= '0;
        end else begin
            edge_sync_q <= {edge_sync_q[1:0], edge_tgl};
            byte_sync_q <= {byte_sync_q[1:0], byte_tgl};
        end
    end

    assign sck_event = edge_sync_q[1] ^ edge_sync_q[2];
    assign byte_event = byte_sync_q[1] ^ byte_sync_q[2];

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    ctrl_t ctrl_q, ctrl_d;

    always_comb begin
        ctrl_d = ctrl_q;
        if (hit(sfr_addr, sfr_wr)) begin
            ctrl_d.master_role_select = sfr_wdata[BIT_ROLE];
            ctrl_d.clock_phase_select = sfr_wdata[BIT_PHASE];
            ctrl_d.clock_idle_level = sfr_wdata[BIT_POL];
        end
    end

    // ------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------
    logic slv_busy_q, slv_busy_d;
    logic shempty_q, shempty_d;
    logic sh_loaded_q, sh_loaded_d;
    logic rxempty_q, rxempty_d;
    logic [7:0] rdata_q, rdata_d;
    status_t st;

    always_comb begin
        slv_busy_d = slv_busy_q;
        if (byte_event || sel_filt) begin
            slv_busy_d = 1'h0;
        end else if (sck_event) begin
            slv_busy_d = 1'h1;
        end
        // loaded byte leaves only at byte end
        sh_loaded_d = sh_loaded_q;
        if (engine.tx_load) begin
            sh_loaded_d = 1'h1;
        end else if (byte_event) begin
            sh_loaded_d = 1'h0;
        end
        shempty_d = shempty_q;
        if (engine.tx_load || sck_event) begin
            shempty_d = 1'h0;
        end else if (!slv_busy_q && !sh_loaded_q && !engine.tx_pending) begin
            shempty_d = 1'h1;
        end
        rxempty_d = rxempty_q;
        if (engine.rx_byte_stored) begin
            rxempty_d = 1'h0;
        end else if (engine.rx_buf_read) begin
            rxempty_d = 1'h1;
        end
    end

    always_comb begin
        st.transfer_in_progress = ctrl_q.master_role_select ? engine.master_busy : slv_busy_q;
        st.selected_flag_filtered = ~sel_filt;
        st.select_pin_raw = sel_raw;
        st.shifter_empty = ctrl_q.master_role_select | shempty_q;
        st.rx_holding_empty = ctrl_q.master_role_select | rxempty_q;
    end

    always_comb begin
        rdata_d = rdata_q;
        if (hit(sfr_addr, sfr_rd)) begin
            rdata_d = RDATA_NONE;
            rdata_d[BIT_BUSY] = st.transfer_in_progress;
            rdata_d[BIT_ROLE] = ctrl_q.master_role_select;
            rdata_d[BIT_PHASE] = ctrl_q.clock_phase_select;
            rdata_d[BIT_POL] = ctrl_q.clock_idle_level;
            rdata_d[BIT_SEL] = st.selected_flag_filtered;
            rdata_d[BIT_PIN] = st.select_pin_raw;
            rdata_d[BIT_SHEMPTY] = st.shifter_empty;
            rdata_d[BIT_RXEMPTY] = st.rx_holding_empty;
        end else if (sfr_rd) begin
            rdata_d = RDATA_NONE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '{RST_CTRL, RST_CTRL, RST_CTRL};
            slv_busy_q <= 1'h0;
            shempty_q <= RST_EMPTY;
            sh_loaded_q <= 1'h0;
            rxempty_q <= RST_EMPTY;
            rdata_q <= RDATA_NONE;
        end else begin
            ctrl_q <= ctrl_d;
            slv_busy_q <= slv_busy_d;
            shempty_q <= shempty_d;
            sh_loaded_q <= sh_loaded_d;
            rxempty_q <= rxempty_d;
            rdata_q <= rdata_d;
        end
    end

    assign ctrl = ctrl_q;
    assign status = st;
    assign sfr_rdata = rdata_q;

endmodule // spi_config_status_reg

// File: testbench/spi_cfg_asserts.sv
`timescale 1ns/1ns
module spi_cfg_asserts #(
    parameter int FILTER_CYC = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    // Engine and link
    input wire spi_cfg_pkg::engine_t engine,
    input wire spi_cfg_pkg::ctrl_t ctrl,
    input wire spi_cfg_pkg::status_t status,
    input wire logic spi_sck,
    input wire logic slave_select_pin
);
    import spi_cfg_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic hit = sfr_addr == CFG_ADDR;
    wire logic slv = !ctrl.master_role_select;
    // Long enough for synchroniser plus filter
    sequence sel_low;
        !slave_select_pin [*8] ##1 !slave_select_pin [*4];
    endsequence
    sequence sel_high;
        slave_select_pin [*8] ##1 slave_select_pin [*4];
    endsequence
    AST_WR_CTRL: assert property (sfr_wr && hit |=> ctrl == $past(sfr_wdata[6:4]))
        else $error("ctrl not loaded by write");
    AST_CTRL_HOLD: assert property (!(sfr_wr && hit) |=> $stable(ctrl))
        else $error("ctrl changed without write");
    AST_RD_CTRL: assert property (sfr_rd && hit |=> sfr_rdata[6:4] == $past(ctrl))
        else $error("read data lacks ctrl bits");
    AST_RD_PIN: assert property (sfr_rd && hit |=> sfr_rdata[2] == $past(status.select_pin_raw))
        else $error("read data lacks raw pin");
    AST_MASTER_ONES: assert property (!slv |-> status.shifter_empty && status.rx_holding_empty)
        else $error("empty flags low in master role");
    AST_RX_FULL: assert property (slv && engine.rx_byte_stored |-> ##[1:2] !status.rx_holding_empty)
        else $error("rx empty not cleared");
    AST_RX_READ: assert property (slv && engine.rx_buf_read && !engine.rx_byte_stored ##1 !engine.rx_byte_stored
        |-> ##[0:1] status.rx_holding_empty) else $error("rx empty not set");
    AST_TX_LOAD: assert property (slv && engine.tx_load |-> ##[1:2] !status.shifter_empty)
        else $error("shifter empty not cleared on load");
    AST_SCK_EDGE: assert property (slv && !slave_select_pin && $rose(spi_sck) |-> ##[1:5] !status.shifter_empty)
        else $error("shifter empty not cleared on clock");
    AST_SEL: assert property (sel_low |-> status.selected_flag_filtered)
        else $error("selected flag not set");
    AST_DESEL: assert property (sel_high |-> !status.selected_flag_filtered)
        else $error("selected flag not cleared");
    AST_BUSY_M: assert property ((!slv && engine.master_busy) [*3] |-> status.transfer_in_progress)
        else $error("busy missing in master role");
endmodule // spi_cfg_asserts

bind spi_config_status_reg spi_cfg_asserts #(.FILTER_CYC(FILTER_CYC)) u_asserts (.sys_clk(sys_clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .engine(engine), .ctrl(ctrl), .status(status), .spi_sck(spi_sck), .slave_select_pin(slave_select_pin));

// File: testbench/spi_far_master.sv
`timescale 1ns/1ns
module spi_far_master (
    // Link pins
    output logic spi_sck,
    output logic slave_select_pin
);
    // Select is pulled up when released
    initial begin
        spi_sck = 1'b0;
        slave_select_pin = 1'b1;
    end
    task automatic set_idle(input logic lvl);
        spi_sck = lvl;
    endtask
    task automatic frame(input int edges);
        slave_select_pin = 1'b0;
        #300;
        repeat (edges) begin
            #62 spi_sck = ~spi_sck;
            #63 spi_sck = ~spi_sck;
        end
        #300 slave_select_pin = 1'b1;
    endtask
    task automatic glitch(input int ns);
        slave_select_pin = 1'b0;
        #(ns) slave_select_pin = 1'b1;
    endtask
endmodule // spi_far_master

// File: testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import spi_cfg_pkg::*;
    logic sys_clk, rst_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, w;
    engine_t engine;
    ctrl_t ctrl;
    status_t status;
    wire logic spi_sck, slave_select_pin;
    int bad_count = 0, total_checks = 0;
    // Reference model state
    int m_ctrl = 0, m_busy = 0, m_sel = 0, m_sh = 1, m_rx = 1, m_pin = 1;
    spi_config_status_reg #(.FILTER_CYC(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .engine(engine),
        .ctrl(ctrl), .status(status), .spi_sck(spi_sck), .slave_select_pin(slave_select_pin));
    spi_far_master far (.spi_sck(spi_sck), .slave_select_pin(slave_select_pin));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        if (a == CFG_ADDR) m_ctrl = d[6:4];
    endtask
    // Master role forces both empty bits high
    task automatic rd(input logic [7:0] a, input logic [7:0] mask);
        logic [7:0] e;
        e = {m_busy[0], 3'(m_ctrl), m_sel[0], m_pin[0], m_sh[0] | m_ctrl[2], m_rx[0] | m_ctrl[2]};
        if (a != CFG_ADDR) e = 8'h00;
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        @(negedge sys_clk);
        total_checks++;
        if ((sfr_rdata & mask) !== (e & mask)) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, sfr_rdata, e);
        end
    endtask
    task automatic pulse(input int b);
        @(posedge sys_clk);
        engine[b] <= 1'b1;
        @(posedge sys_clk);
        engine[b] <= 1'b0;
        if (b == 1) m_rx = 0;
        if (b == 0) m_rx = 1;
        if (b == 2) m_sh = 0;
    endtask
    initial begin
        #300000;
        bad_count++;
        end_sim();
    end
    initial begin
        rst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        engine = '0;
        void'($urandom(93));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(CFG_ADDR, 8'hff);
        repeat (8) begin
            w = 8'($urandom);
            wr(CFG_ADDR, w);
            rd(CFG_ADDR, 8'hff);
        end
        w = 8'($urandom);
        if (w == CFG_ADDR) w = 8'h00;
        wr(w, 8'hff);
        rd(w, 8'hff);
        rd(CFG_ADDR, 8'hff);
        $display("test registers done");
        wr(CFG_ADDR, 8'h40);
        engine.master_busy <= 1'b1;
        m_busy = 1;
        pulse(1);
        rd(CFG_ADDR, 8'hff);
        engine.master_busy <= 1'b0;
        m_busy = 0;
        wr(CFG_ADDR, 8'h00);
        pulse(0);
        rd(CFG_ADDR, 8'hff);
        pulse(1);
        rd(CFG_ADDR, 8'hff);
        pulse(0);
        rd(CFG_ADDR, 8'hff);
        $display("test buffers done");
        for (int i = 0; i < 4; i++) begin
            wr(CFG_ADDR, 8'(i << 4));
            far.set_idle(i[0]);
            engine.tx_pending <= 1'b1;
            pulse(2);
            engine.tx_pending <= 1'b0;
            rd(CFG_ADDR, 8'hff);
            fork
                far.frame(8);
                begin
                    #800;
                    m_busy = 1;
                    m_sel = 1;
                    m_pin = 0;
                    rd(CFG_ADDR, 8'hfe);
                end
            join
            repeat (20) @(posedge sys_clk);
            m_busy = 0;
            m_sel = 0;
            m_pin = 1;
            m_sh = 1;
            rd(CFG_ADDR, 8'hff);
        end
        $display("test frames done");
        // Pulse passes the synchroniser but is shorter than the filter
        fork
            far.glitch(30);
            begin
                repeat (3) @(posedge sys_clk);
                m_pin = 0;
                rd(CFG_ADDR, 8'h0c);
            end
        join
        m_pin = 1;
        repeat (5) @(posedge sys_clk);
        rd(CFG_ADDR, 8'h0c);
        $display("test glitch done");
        end_sim();
    end
endmodule // testbench
